/* File: sprite_ctrl_pkg.sv */
// Purpose: Constants for the sprite engine control block.
// Assumes: 16-bit registers on a plain strobe port, 10 MHz system clock.
// Notes: Register offsets are byte addresses.
// Contract
// R1: Pixels written in selected frame buffer format.
// R2: Double buffer bit alternates two frame buffers.
// R3: Double buffer clear uses buffer zero only.
// R4: Software leaves registers alone while disabled.
// R5: Enable with conversion clear activates sprite engine.
// R6: Converter enabled only when both bits set.
// R7: Trigger mode is bits 10-8, two reserved.
// R8: Mode zero starts only on manual trigger.
// R9: Modes one-five start every N vertical syncs.
// R10: Manual controls apply to selected sprite number.
// R11: Software clears completion flag between periodic operations.
// R12: Read-only busy status, resets to 8000 hex.
package sprite_ctrl_pkg;
   // ==========================================================
   // Register map
   localparam logic [15:0] CONFIG_ADDR = 16'h1700;
   localparam logic [15:0] TRIGGER_ADDR = 16'h1704;
   localparam logic [15:0] STATUS_ADDR = 16'h1702;
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [15:0] TRIGGER_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h8000;
   // ==========================================================
   // Field positions
   localparam int CFG_ENABLE_BIT = 0;
   localparam int CFG_DOUBLE_BIT = 1;
   localparam int CFG_FBFMT_LO = 2;
   localparam int CFG_CONV_BIT = 8;
   localparam int CFG_SWRESET_BIT = 15;
   localparam int TRG_MANUAL_BIT = 0;
   localparam int TRG_NEXT_BIT = 1;
   localparam int TRG_PREV_BIT = 2;
   localparam int TRG_NUM_LO = 4;
   localparam int TRG_MODE_LO = 8;
   localparam int STATUS_BUSY_BIT = 15;
   localparam logic [15:0] CONFIG_MASK = 16'h81BF;
   localparam logic [15:0] TRIGGER_MASK = 16'h07F0;
   // ==========================================================
   // Encodings
   localparam logic [1:0] FMT_RGB565 = 2'h0;
   localparam logic [1:0] FMT_RGB332 = 2'h1;
   localparam logic [1:0] FMT_RGB888 = 2'h2;
   localparam logic [2:0] MODE_MANUAL = 3'h0;
   localparam logic [2:0] MODE_MAX_VSYNC = 3'h5;
   localparam logic [1:0] BPP_16 = 2'h0;
   localparam logic [1:0] BPP_8 = 2'h1;
   localparam logic [1:0] BPP_24 = 2'h2;
endpackage

/* File: vsync_divider.sv */
// Purpose: Counts vertical sync pulses and issues a start every N of them.
// Assumes: i_vsync_pulse is one cycle long and already synchronised.
// Notes: Counter restarts whenever the period changes or divider is off.
`timescale 1ns/10ps
module vsync_divider
   import sprite_ctrl_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_run,
   input wire logic [WIDTH-1:0] i_period,
   input wire logic i_vsync_pulse,
   output logic o_tick
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] period_reg;
   logic last_count;

   assign last_count = (count_reg + WIDTH'(1)) >= i_period;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || !i_run || (period_reg != i_period)) begin
         count_reg <= '0;
      end else if (i_vsync_pulse) begin
         count_reg <= last_count ? '0 : count_reg + WIDTH'(1); // see R9
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         period_reg <= '0;
      end else begin
         period_reg <= i_period;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= i_run && (period_reg == i_period) && i_vsync_pulse && last_count;
      end
   end
endmodule

/* File: sprite_engine_control.sv */
// Purpose: Configuration, mode select and trigger logic of the sprite engine.
// Assumes: Engine datapath outside reports completion by o_start/i_op_done.
// Notes: Vertical sync arrives from the panel timing, asynchronous here.
`timescale 1ns/10ps
module sprite_engine_control
   import sprite_ctrl_pkg::*;
#(
   parameter int SPRITES = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_vsync,
   input wire logic i_op_done,
   input wire logic i_done_flag,
   output logic o_engine_active,
   output logic o_conv_active,
   output logic [1:0] o_fb_format,
   output logic [1:0] o_bytes_per_pixel,
   output logic o_fmt_reserved,
   output logic o_buf_select,
   output logic o_start,
   output logic [3:0] o_sprite_num,
   output logic o_frame_next,
   output logic o_frame_prev,
   output logic o_mode_reserved
);
   logic [15:0] config_reg;
   logic [15:0] trigger_reg;
   logic busy_reg;
   logic buf_sel_reg;
   logic [2:0] vsync_sync_reg;
   logic vsync_level_reg;
   logic vsync_pulse;
   logic cfg_wr;
   logic trg_wr;
   logic enabled;
   logic [2:0] mode;
   logic manual_mode;
   logic period_mode;
   logic vsync_tick;
   logic manual_go;
   logic start_next;

   // ==========================================================
   // Register writes
   assign cfg_wr = i_wr && (i_addr == CONFIG_ADDR);
   assign trg_wr = i_wr && (i_addr == TRIGGER_ADDR);

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || config_reg[CFG_SWRESET_BIT]) begin
         config_reg <= CONFIG_RESET;
      end else if (cfg_wr) begin
         config_reg <= i_wdata & CONFIG_MASK;
      end
   end

   // Action bits are not stored; they pulse on the write itself
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || config_reg[CFG_SWRESET_BIT]) begin
         trigger_reg <= TRIGGER_RESET;
      end else if (trg_wr) begin
         trigger_reg <= i_wdata & TRIGGER_MASK;
      end
   end

   // ==========================================================
   // Mode decode
   assign enabled = config_reg[CFG_ENABLE_BIT];
   assign mode = trigger_reg[TRG_MODE_LO +: 3];
   assign manual_mode = (mode == MODE_MANUAL); // see R7
   assign period_mode = !manual_mode && (mode <= MODE_MAX_VSYNC); // see R7
   assign o_mode_reserved = mode > MODE_MAX_VSYNC;
   assign o_engine_active = enabled && !config_reg[CFG_CONV_BIT]; // see R5
   assign o_conv_active = enabled && config_reg[CFG_CONV_BIT]; // see R6
   assign o_fb_format = config_reg[CFG_FBFMT_LO +: 2]; // see R1
   assign o_sprite_num = trigger_reg[TRG_NUM_LO +: 4];

   always_comb begin
      o_fmt_reserved = 1'b0;
      unique case (o_fb_format)
         FMT_RGB565: o_bytes_per_pixel = BPP_16; // see R1
         FMT_RGB332: o_bytes_per_pixel = BPP_8;
         FMT_RGB888: o_bytes_per_pixel = BPP_24;
         default: begin
            o_bytes_per_pixel = BPP_16;
            o_fmt_reserved = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // Vertical sync input: three stages, change taken when last two agree
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         vsync_sync_reg <= 3'h0;
      end else begin
         vsync_sync_reg <= {vsync_sync_reg[1:0], i_vsync};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         vsync_level_reg <= 1'b0;
      end else if (vsync_sync_reg[1] == vsync_sync_reg[2]) begin
         vsync_level_reg <= vsync_sync_reg[2];
      end
   end

   assign vsync_pulse = (vsync_sync_reg[1] == vsync_sync_reg[2]) && vsync_sync_reg[2]
                        && !vsync_level_reg;

   vsync_divider #(
      .WIDTH($bits(mode))
   ) u_divider (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_run(enabled && period_mode),
      .i_period(mode),
      .i_vsync_pulse(vsync_pulse),
      .o_tick(vsync_tick)
   );

   // ==========================================================
   // Triggering
   // Software must keep next/prev apart from manual trigger
   assign manual_go = trg_wr && manual_mode && i_wdata[TRG_MANUAL_BIT]; // see R8
   // Periodic start held off until software clears the completion flag
   assign start_next = enabled && !busy_reg &&
                       (manual_go || (period_mode && vsync_tick && !i_done_flag)); // see R9, R11

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || config_reg[CFG_SWRESET_BIT]) begin
         o_start <= 1'b0;
         o_frame_next <= 1'b0;
         o_frame_prev <= 1'b0;
      end else begin
         o_start <= start_next;
         o_frame_next <= trg_wr && manual_mode && enabled && i_wdata[TRG_NEXT_BIT]; // see R10
         o_frame_prev <= trg_wr && manual_mode && enabled && i_wdata[TRG_PREV_BIT]; // see R10
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || config_reg[CFG_SWRESET_BIT]) begin
         busy_reg <= 1'b0;
      end else if (start_next) begin
         busy_reg <= 1'b1; // see R12
      end else if (i_op_done) begin
         busy_reg <= 1'b0;
      end
   end

   // Alternate buffers on each finished frame in double mode only
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || config_reg[CFG_SWRESET_BIT] || !config_reg[CFG_DOUBLE_BIT]) begin
         buf_sel_reg <= 1'b0; // see R3
      end else if (busy_reg && i_op_done && o_engine_active) begin
         buf_sel_reg <= !buf_sel_reg; // see R2
      end
   end

   assign o_buf_select = buf_sel_reg;

   // ==========================================================
   // Read port
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         unique case (i_addr)
            CONFIG_ADDR: o_rdata <= config_reg;
            TRIGGER_ADDR: o_rdata <= trigger_reg;
            STATUS_ADDR: o_rdata <= busy_reg ? 16'h0000 : STATUS_RESET; // see R12
            default: o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // ==========================================================
   // Checks
   engine_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !(o_engine_active && o_conv_active)) // see R5
      else $error("engine and converter both active");
   conv_enable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_conv_active |-> config_reg[CFG_ENABLE_BIT] && config_reg[CFG_CONV_BIT]) // see R6
      else $error("converter active without both bits");
   manual_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_start && $past(manual_mode) |-> $past(trg_wr)) // see R8
      else $error("manual mode start without write");
   single_buf_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !config_reg[CFG_DOUBLE_BIT] |=> !o_buf_select) // see R3
      else $error("buffer one used in single mode");
   double_buf_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      config_reg[CFG_DOUBLE_BIT] && busy_reg && i_op_done && o_engine_active
      && !config_reg[CFG_SWRESET_BIT] && !cfg_wr |=> o_buf_select != $past(o_buf_select)) // see R2
      else $error("buffer did not alternate");
   periodic_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_start && !$past(manual_mode) |-> $past(vsync_tick)) // see R9
      else $error("periodic start without vsync tick");
   busy_status_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_rd && i_addr == STATUS_ADDR |=> o_rdata[STATUS_BUSY_BIT] == !$past(busy_reg)) // see R12
      else $error("status busy bit wrong");
   format_decode_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_fb_format == FMT_RGB332 |-> o_bytes_per_pixel == BPP_8 && !o_fmt_reserved) // see R1
      else $error("frame buffer format decode wrong");
   frame_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_frame_next |-> $past(manual_mode) && $past(trg_wr)) // see R10
      else $error("frame step outside manual mode");
   mode_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_mode_reserved |-> !period_mode && !manual_mode) // see R7
      else $error("reserved mode treated as valid");
   done_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      period_mode && i_done_flag |=> !o_start) // see R11
      else $error("periodic start while completion flag set");
   enabled_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_start |-> $past(enabled)) // see R5
      else $error("start while module disabled");
   busy_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      busy_reg && !i_op_done && !config_reg[CFG_SWRESET_BIT] |=> busy_reg) // see R12
      else $error("busy dropped before completion");
endmodule

/* File: test_sprite_engine_control.sv */
// Purpose: Self-checking bench for the sprite engine control block.
// Assumes: Status at the package offset, busy bit 15 low while busy.
// Notes: Bench drives every port itself; module enabled before other writes.
`timescale 1ns/10ps
module test_sprite_engine_control
   import sprite_ctrl_pkg::*;
;
   logic i_clk_sys, i_rstn, i_wr, i_rd, i_vsync, i_op_done, i_done_flag;
   logic [15:0] i_addr, i_wdata, o_rdata;
   logic o_engine_active, o_conv_active, o_fmt_reserved, o_buf_select;
   logic o_start, o_frame_next, o_frame_prev, o_mode_reserved;
   logic [1:0] o_fb_format, o_bytes_per_pixel;
   logic [3:0] o_sprite_num;
   int fail_count = 0;
   int total_checks = 0;
   logic [15:0] v;
   int n;

   sprite_engine_control DUT (.i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_vsync, .i_op_done, .i_done_flag, .o_engine_active, .o_conv_active,
      .o_fb_format, .o_bytes_per_pixel, .o_fmt_reserved, .o_buf_select, .o_start,
      .o_sprite_num, .o_frame_next, .o_frame_prev, .o_mode_reserved);

   // ==========================================================
   // Bus and pin tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      @(negedge i_clk_sys);
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(negedge i_clk_sys);
      d = o_rdata;
   endtask

   task automatic op_done;
      @(posedge i_clk_sys);
      i_op_done <= 1'b1;
      @(posedge i_clk_sys);
      i_op_done <= 1'b0;
      @(negedge i_clk_sys);
   endtask

   // Bounded window: counts starts seen while one vsync goes by
   task automatic vs(output int starts);
      starts = 0;
      for (int i = 0; i < 12; i++) begin
         @(posedge i_clk_sys);
         i_vsync <= (i < 4);
         @(negedge i_clk_sys);
         if (o_start === 1'b1) starts++;
      end
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd(CONFIG_ADDR, v);
      check("config", v, CONFIG_RESET);
      rd(TRIGGER_ADDR, v);
      check("trigger", v, TRIGGER_RESET);
      rd(STATUS_ADDR, v);
      check("status", v, STATUS_RESET);
      rd(16'h1706, v);
      check("unmapped", v, 16'h0000);
      check("buf", 16'(o_buf_select), 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_modes;
      for (int k = 0; k < 4; k++) begin
         wr(CONFIG_ADDR, 16'((k / 2) << CFG_CONV_BIT) | 16'(k % 2));
         check("engine", 16'(o_engine_active), 16'(k == 1));
         check("conv", 16'(o_conv_active), 16'(k == 3));
      end
      for (int f = 0; f < 4; f++) begin
         wr(CONFIG_ADDR, 16'h0001 | 16'(f << CFG_FBFMT_LO));
         check("format", 16'(o_fb_format), 16'(f));
         check("fmt rsvd", 16'(o_fmt_reserved), 16'(f == 3));
         if (f < 3) check("bpp", 16'(o_bytes_per_pixel), 16'(f));
      end
      $display("test modes done");
   endtask

   task automatic t_manual;
      wr(CONFIG_ADDR, 16'h0001);
      wr(TRIGGER_ADDR, 16'h0051);
      check("start", 16'(o_start), 16'h0001);
      check("number", 16'(o_sprite_num), 16'h0005);
      rd(STATUS_ADDR, v);
      check("busy", v, 16'h0000);
      wr(TRIGGER_ADDR, 16'h0051);
      check("busy start", 16'(o_start), 16'h0000);
      op_done();
      rd(STATUS_ADDR, v);
      check("idle", v, STATUS_RESET);
      wr(TRIGGER_ADDR, 16'h00A2);
      check("next", 16'(o_frame_next), 16'h0001);
      check("number", 16'(o_sprite_num), 16'h000A);
      wr(TRIGGER_ADDR, 16'h00F4);
      check("prev", 16'(o_frame_prev), 16'h0001);
      rd(TRIGGER_ADDR, v);
      check("trig rd", v, 16'h00F0);
      $display("test manual done");
   endtask

   task automatic t_buffers;
      wr(CONFIG_ADDR, 16'h0003);
      for (int k = 1; k <= 3; k++) begin
         wr(TRIGGER_ADDR, 16'h0001);
         op_done();
         check("buf dbl", 16'(o_buf_select), 16'(k % 2));
      end
      wr(CONFIG_ADDR, 16'h0001);
      wr(TRIGGER_ADDR, 16'h0001);
      op_done();
      check("buf single", 16'(o_buf_select), 16'h0000);
      $display("test buffers done");
   endtask

   task automatic t_periodic;
      for (int m = 1; m <= 5; m++) begin
         wr(TRIGGER_ADDR, 16'(m << TRG_MODE_LO));
         for (int k = 1; k <= m; k++) begin
            vs(n);
            check("vsync starts", 16'(n), 16'(k == m));
            op_done();
         end
      end
      wr(TRIGGER_ADDR, 16'h0101);
      check("manual in periodic", 16'(o_start), 16'h0000);
      @(posedge i_clk_sys);
      i_done_flag <= 1'b1;
      vs(n);
      check("flag held", 16'(n), 16'h0000);
      @(posedge i_clk_sys);
      i_done_flag <= 1'b0;
      for (int m = 0; m < 8; m++) begin
         wr(TRIGGER_ADDR, 16'(m << TRG_MODE_LO));
         check("mode rsvd", 16'(o_mode_reserved), 16'(m >= 6));
      end
      vs(n);
      check("rsvd starts", 16'(n), 16'h0000);
      wr(TRIGGER_ADDR, 16'h0000);
      vs(n);
      check("manual vsync", 16'(n), 16'h0000);
      $display("test periodic done");
   endtask

   // Soft reset bit must clear config, trigger, busy and buffer choice
   task automatic t_soft_reset;
      wr(CONFIG_ADDR, 16'h0003);
      wr(TRIGGER_ADDR, 16'h0051);
      op_done();
      check("buf pre", 16'(o_buf_select), 16'h0001);
      wr(TRIGGER_ADDR, 16'h0051);
      wr(CONFIG_ADDR, 16'h8003);
      rd(CONFIG_ADDR, v);
      check("soft config", v, CONFIG_RESET);
      rd(TRIGGER_ADDR, v);
      check("soft trigger", v, TRIGGER_RESET);
      rd(STATUS_ADDR, v);
      check("soft status", v, STATUS_RESET);
      check("soft buf", 16'(o_buf_select), 16'h0000);
      $display("test soft reset done");
   endtask

   // ==========================================================
   // Clock, reset, sequence
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   initial begin
      #1000000;
      fail_count++;
      give_verdict();
   end

   initial begin
      i_rstn = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 16'h0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_vsync = 1'b0;
      i_op_done = 1'b0;
      i_done_flag = 1'b0;
      repeat (3) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      t_reset();
      t_modes();
      t_manual();
      t_buffers();
      t_periodic();
      t_soft_reset();
      give_verdict();
   end
endmodule
